// ==== verilog/oamu_core.v ====
// Operand address-mode evaluation, group decode and move execution
// How it works
// - Mode 0: the selected register itself is the operand, no memory access.
// - Mode 1: register holds the operand address; register unchanged.
// - Mode 2, not PC: access at register, then add step size to it.
// - Mode 3, not PC: read pointer at register, then register plus 2 always.
// - Mode 4: subtract step size first, then use new value as address.
// - Mode 5: decrement first, then read pointer at the new address.
// - Mode 6, not PC: next stream word plus register is the address.
// - Mode 7, not PC: stream word plus register points to the address.
// - Mode 2 on PC: next stream word is the immediate operand, PC skips it.
// - Mode 3 on PC: next stream word is the absolute operand address.
// - Mode 6 on PC: stream word plus updated PC is the address.
// - Mode 7 on PC: stream word plus PC points to the address.
// - Source and destination specifiers are mode and register fields.
// - Every instruction falls in one of seven groups.
// - Floating-point opcodes are handed to the coprocessor, not executed.
// - Word move copies; N from bit 15, Z if zero, V cleared.
// - Byte move copies; N from bit 7, Z if low byte zero, V cleared.
// - Step size is 2 for words and 1 for bytes, except 2 for bytes on the PC.
// - Register 7 is the program counter.
`timescale 1ns/1ps
`include "oamu_consts.vh"
module oamu_core (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Main memory
    output wire        mem_req,
    output wire        mem_we,
    output wire        mem_byte,
    output wire [15:0] mem_addr,
    output wire [15:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [15:0] mem_rdata,
    // Floating-point coprocessor
    output wire        fp_valid,
    output wire [15:0] fp_instr,
    input  wire        fp_done
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_DECD = 4'h1;
    localparam [3:0] S_SPEC = 4'h2;
    localparam [3:0] S_XFET = 4'h3;
    localparam [3:0] S_INDX = 4'h4;
    localparam [3:0] S_DEFR = 4'h5;
    localparam [3:0] S_OPRD = 4'h6;
    localparam [3:0] S_WRIT = 4'h7;
    localparam [3:0] S_FPWT = 4'h8;

    reg [3:0]  st_r;
    reg        phase_r;
    reg [15:0] ir_r;
    reg [15:0] src_r;
    reg [15:0] x_r;
    reg [15:0] ea_r;
    reg [15:0] res_r;
    reg [3:0]  cc_r;
    reg        done_r;
    reg        moved_r;
    reg [31:0] prdata_r;
    reg        pready_r;
    reg        pslverr_r;
    reg        mem_req_r;
    reg        mem_we_r;
    reg        mem_byte_r;
    reg [15:0] mem_addr_r;
    reg [15:0] mem_wdata_r;
    reg        fp_valid_r;
    reg [15:0] fp_instr_r;

    reg [2:0]  grp;
    reg        rf_we;
    reg [15:0] rf_wd;
    reg [31:0] rd_mux;
    reg        acc_err;

    wire [5:0]  spec    = phase_r ? ir_r[`OAMU_DST_MSB:`OAMU_DST_LSB]
                                  : ir_r[`OAMU_SRC_MSB:`OAMU_SRC_LSB];
    wire [2:0]  mode    = spec[5:3];
    wire [2:0]  rnum    = spec[2:0];
    wire        is_byte = ir_r[`OAMU_BYTE_BIT];
    wire        is_move = (ir_r[14:12] == 3'h1);
    wire        is_pc   = (rnum == `OAMU_PC_NUM);
    wire [15:0] step    = (is_byte && !is_pc) ? `OAMU_STEP_B : `OAMU_STEP_W;
    wire [15:0] rval;
    wire [15:0] apb_rval;
    wire [15:0] pc_val;
    wire [15:0] byte_rd = mem_addr_r[0] ? {{8{mem_rdata[15]}}, mem_rdata[15:8]}
                                        : {{8{mem_rdata[7]}}, mem_rdata[7:0]};
    wire [15:0] idx_sum = x_r + rval;
    wire        setup   = psel & ~penable;
    wire        access  = psel & penable & pready_r;
    wire        wr_ok   = access & pwrite & ~pslverr_r;
    wire        grf_sel = (paddr[7:5] == `OAMU_A_GRF_HI);

    oamu_grf u_grf (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (rf_we),
        .wa      ((st_r == S_IDLE) ? paddr[4:2] : ((st_r == S_XFET) ? `OAMU_PC_NUM : rnum)),
        .wd      (rf_wd),
        .ra      (rnum),
        .rd_a    (rval),
        .rb      (paddr[4:2]),
        .rd_b    (apb_rval),
        .pc      (pc_val)
    );

    // Instruction group classification
    always @* begin
        grp = `OAMU_G_SINGLE;
        if (ir_r[15:12] == 4'hF) begin
            grp = `OAMU_G_FLOAT;
        end else if (ir_r[15:12] == 4'h7) begin
            grp = `OAMU_G_REGOP;
        end else if (ir_r[14:12] != 3'h0) begin
            grp = `OAMU_G_DOUBLE;
        end else if (ir_r[11:9] == 3'h4) begin
            grp = `OAMU_G_PCTL;
        end else if (!ir_r[11] && (ir_r[15] || ir_r[10:8] != 3'h0)) begin
            grp = `OAMU_G_PCTL;
        end else if (!ir_r[15] && ir_r[11:6] == 6'h34) begin
            grp = `OAMU_G_PCTL;
        end else if (ir_r[15:8] == 8'h00) begin
            case (ir_r[7:6])
                2'h0: grp = `OAMU_G_OPER;
                2'h1: grp = `OAMU_G_PCTL;
                2'h2: begin
                    if (ir_r[5]) begin
                        grp = `OAMU_G_CCOP;
                    end else if (ir_r[5:3] == 3'h0) begin
                        grp = `OAMU_G_PCTL;
                    end else begin
                        grp = `OAMU_G_OPER;
                    end
                end
                default: grp = `OAMU_G_SINGLE;
            endcase
        end
    end

    // Register side effects
    always @* begin
        rf_we = 1'b0;
        rf_wd = `OAMU_RST_W16;
        case (st_r)
            S_IDLE: begin
                rf_we = wr_ok & grf_sel;
                rf_wd = pwdata[15:0];
            end
            S_SPEC: begin
                case (mode)
                    `OAMU_M_REG: begin
                        rf_we = phase_r;
                        rf_wd = is_byte ? {{8{src_r[7]}}, src_r[7:0]} : src_r;
                    end
                    `OAMU_M_AINC: begin
                        rf_we = 1'b1;
                        rf_wd = rval + step;
                    end
                    `OAMU_M_AINCD: begin
                        rf_we = 1'b1;
                        rf_wd = rval + `OAMU_STEP_W;
                    end
                    `OAMU_M_ADEC: begin
                        rf_we = 1'b1;
                        rf_wd = rval - step;
                    end
                    `OAMU_M_ADECD: begin
                        rf_we = 1'b1;
                        rf_wd = rval - `OAMU_STEP_W;
                    end
                    default: rf_we = 1'b0;
                endcase
            end
            S_XFET: begin
                rf_we = mem_ack;
                rf_wd = pc_val + `OAMU_XW_ADV;
            end
            default: rf_we = 1'b0;
        endcase
    end

    // APB read data and error decode
    always @* begin
        rd_mux  = 32'h0000_0000;
        acc_err = (paddr[1:0] != 2'h0);
        if (grf_sel) begin
            rd_mux  = {16'h0000, apb_rval};
            acc_err = acc_err | (pwrite & (st_r != S_IDLE));
        end else begin
            case (paddr)
                `OAMU_A_INSTR: begin
                    rd_mux  = {16'h0000, ir_r};
                    acc_err = acc_err | (pwrite & (st_r != S_IDLE));
                end
                `OAMU_A_STAT: begin
                    rd_mux[`OAMU_ST_BUSY] = (st_r != S_IDLE);
                    rd_mux[`OAMU_ST_DONE] = done_r;
                    rd_mux[`OAMU_ST_GRP_MSB:`OAMU_ST_GRP_LSB] = grp;
                    rd_mux[`OAMU_ST_FP]   = fp_valid_r;
                    rd_mux[`OAMU_ST_MOVE] = moved_r;
                    acc_err = acc_err | pwrite;
                end
                `OAMU_A_PSW: begin
                    rd_mux  = {28'h000_0000, cc_r};
                    acc_err = acc_err | (pwrite & (st_r != S_IDLE));
                end
                `OAMU_A_RES: begin
                    rd_mux  = {16'h0000, res_r};
                    acc_err = acc_err | pwrite;
                end
                `OAMU_A_EA: begin
                    rd_mux  = {16'h0000, ea_r};
                    acc_err = acc_err | pwrite;
                end
                default: acc_err = 1'b1;
            endcase
        end
    end

    task launch;
        input [15:0] a;
        input        wr;
        input        bt;
        begin
            mem_req_r   <= 1'b1;
            mem_addr_r  <= a;
            mem_we_r    <= wr;
            mem_byte_r  <= bt;
            mem_wdata_r <= bt ? {src_r[7:0], src_r[7:0]} : src_r;
        end
    endtask

    task operand_at;
        input [15:0] a;
        begin
            ea_r <= a;
            launch(a, phase_r, is_byte);
            st_r <= phase_r ? S_WRIT : S_OPRD;
        end
    endtask

    task finish_move;
        begin
            res_r   <= src_r;
            moved_r <= 1'b1;
            done_r  <= 1'b1;
            st_r    <= S_IDLE;
            cc_r[`OAMU_CC_V] <= 1'b0;
            if (is_byte) begin
                cc_r[`OAMU_CC_N] <= src_r[7];
                cc_r[`OAMU_CC_Z] <= (src_r[7:0] == 8'h00);
            end else begin
                cc_r[`OAMU_CC_N] <= src_r[15];
                cc_r[`OAMU_CC_Z] <= (src_r == 16'h0000);
            end
        end
    endtask

    // APB handshake: no wait states, answer latched in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= acc_err;
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= S_IDLE;
            phase_r     <= 1'b0;
            ir_r        <= `OAMU_RST_W16;
            src_r       <= `OAMU_RST_W16;
            x_r         <= `OAMU_RST_W16;
            ea_r        <= `OAMU_RST_W16;
            res_r       <= `OAMU_RST_W16;
            cc_r        <= `OAMU_RST_CC;
            done_r      <= 1'b0;
            moved_r     <= 1'b0;
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_byte_r  <= 1'b0;
            mem_addr_r  <= `OAMU_RST_W16;
            mem_wdata_r <= `OAMU_RST_W16;
            fp_valid_r  <= 1'b0;
            fp_instr_r  <= `OAMU_RST_W16;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (wr_ok && paddr == `OAMU_A_PSW) begin
                        cc_r <= pwdata[3:0];
                    end
                    if (wr_ok && paddr == `OAMU_A_INSTR) begin
                        ir_r    <= pwdata[15:0];
                        done_r  <= 1'b0;
                        moved_r <= 1'b0;
                        st_r    <= S_DECD;
                    end
                end
                S_DECD: begin
                    phase_r <= 1'b0;
                    if (grp == `OAMU_G_FLOAT) begin
                        fp_valid_r <= 1'b1;
                        fp_instr_r <= ir_r;
                        st_r       <= S_FPWT;
                    end else if (is_move) begin
                        st_r <= S_SPEC;
                    end else begin
                        done_r <= 1'b1;
                        st_r   <= S_IDLE;
                    end
                end
                S_SPEC: begin
                    case (mode)
                        `OAMU_M_REG: begin
                            if (phase_r) begin
                                finish_move;
                            end else begin
                                src_r   <= is_byte ? {{8{rval[7]}}, rval[7:0]} : rval;
                                phase_r <= 1'b1;
                            end
                        end
                        `OAMU_M_DEF:   operand_at(rval);
                        `OAMU_M_AINC:  operand_at(rval);
                        `OAMU_M_AINCD: begin
                            launch(rval, 1'b0, 1'b0);
                            st_r <= S_DEFR;
                        end
                        `OAMU_M_ADEC:  operand_at(rval - step);
                        `OAMU_M_ADECD: begin
                            launch(rval - `OAMU_STEP_W, 1'b0, 1'b0);
                            st_r <= S_DEFR;
                        end
                        default: begin
                            launch(pc_val, 1'b0, 1'b0);
                            st_r <= S_XFET;
                        end
                    endcase
                end
                S_XFET: begin
                    if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        x_r       <= mem_rdata;
                        st_r      <= S_INDX;
                    end
                end
                S_INDX: begin
                    if (mode == `OAMU_M_IDX) begin
                        operand_at(idx_sum);
                    end else begin
                        launch(idx_sum, 1'b0, 1'b0);
                        st_r <= S_DEFR;
                    end
                end
                S_DEFR: begin
                    if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        operand_at(mem_rdata);
                    end
                end
                S_OPRD: begin
                    if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        src_r     <= is_byte ? byte_rd : mem_rdata;
                        phase_r   <= 1'b1;
                        st_r      <= S_SPEC;
                    end
                end
                S_WRIT: begin
                    if (mem_ack) begin
                        mem_req_r <= 1'b0;
                        finish_move;
                    end
                end
                S_FPWT: begin
                    if (fp_done) begin
                        fp_valid_r <= 1'b0;
                        done_r     <= 1'b1;
                        st_r       <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign mem_req   = mem_req_r;
    assign mem_we    = mem_we_r;
    assign mem_byte  = mem_byte_r;
    assign mem_addr  = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign fp_valid  = fp_valid_r;
    assign fp_instr  = fp_instr_r;
endmodule // oamu_core

// ==== verilog/oamu_consts.vh ====
// Constants for the operand address-mode unit
`ifndef OAMU_CONSTS_VH
`define OAMU_CONSTS_VH

// Register byte offsets on the APB
`define OAMU_A_INSTR    8'h00
`define OAMU_A_STAT     8'h04
`define OAMU_A_PSW      8'h08
`define OAMU_A_RES      8'h0C
`define OAMU_A_EA       8'h10
`define OAMU_A_GRF_HI   3'h1

// Instruction field positions
`define OAMU_SRC_MSB    11
`define OAMU_SRC_LSB    6
`define OAMU_DST_MSB    5
`define OAMU_DST_LSB    0
`define OAMU_BYTE_BIT   15

// Address modes
`define OAMU_M_REG      3'h0
`define OAMU_M_DEF      3'h1
`define OAMU_M_AINC     3'h2
`define OAMU_M_AINCD    3'h3
`define OAMU_M_ADEC     3'h4
`define OAMU_M_ADECD    3'h5
`define OAMU_M_IDX      3'h6
`define OAMU_M_IDXD     3'h7
`define OAMU_PC_NUM     3'h7

// Step sizes
`define OAMU_STEP_W     16'h0002
`define OAMU_STEP_B     16'h0001
`define OAMU_XW_ADV     16'h0002

// Instruction groups
`define OAMU_G_DOUBLE   3'h0
`define OAMU_G_REGOP    3'h1
`define OAMU_G_SINGLE   3'h2
`define OAMU_G_PCTL     3'h3
`define OAMU_G_OPER     3'h4
`define OAMU_G_CCOP     3'h5
`define OAMU_G_FLOAT    3'h6

// Status bit positions
`define OAMU_ST_BUSY    0
`define OAMU_ST_DONE    1
`define OAMU_ST_GRP_LSB 2
`define OAMU_ST_GRP_MSB 4
`define OAMU_ST_FP      5
`define OAMU_ST_MOVE    6

// Condition-code bit positions
`define OAMU_CC_N       3
`define OAMU_CC_Z       2
`define OAMU_CC_V       1
`define OAMU_CC_C       0

// Reset values
`define OAMU_RST_W16    16'h0000
`define OAMU_RST_CC     4'h0

`endif

// ==== verilog/oamu_grf.v ====
// General register file, eight words, one write port
`timescale 1ns/1ps
`include "oamu_consts.vh"
module oamu_grf (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Write port
    input  wire        we,
    input  wire [2:0]  wa,
    input  wire [15:0] wd,
    // Read ports
    input  wire [2:0]  ra,
    output wire [15:0] rd_a,
    input  wire [2:0]  rb,
    output wire [15:0] rd_b,
    output wire [15:0] pc
);
    reg [15:0] gr_r [0:7];
    integer    i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                gr_r[i] <= `OAMU_RST_W16;
            end
        end else if (we) begin
            gr_r[wa] <= wd;
        end
    end

    assign rd_a = gr_r[ra];
    assign rd_b = gr_r[rb];
    assign pc   = gr_r[`OAMU_PC_NUM];
endmodule // oamu_grf

// ==== verif/oamu_core_chk.sv ====
// Port checker for the operand address-mode unit
`timescale 1ns/1ps
module oamu_core_chk (
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Memory
    input logic        mem_req,
    input logic        mem_we,
    input logic        mem_byte,
    input logic [15:0] mem_addr,
    input logic [15:0] mem_wdata,
    input logic        mem_ack,
    input logic [15:0] mem_rdata,
    // Coprocessor
    input logic        fp_valid,
    input logic [15:0] fp_instr,
    input logic        fp_done
);
    logic [15:0] instr_r;
    logic [15:0] ptr_r;
    logic [3:0]  acks_r;
    wire wr_ins = psel && penable && pready && pwrite && paddr == 8'h00 && !pslverr;
    wire rd_st = psel && penable && pready && !pwrite && paddr == 8'h04;
    wire ack = mem_req && mem_ack;
    wire is_w = instr_r[15:12] == 4'h1;
    wire is_b = instr_r[15:12] == 4'h9;
    wire defer = (is_w || is_b) && (instr_r[11:9] == 3'h3 || instr_r[11:9] == 3'h5);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= 16'h0000;
            ptr_r <= 16'h0000;
            acks_r <= 4'h0;
        end else begin
            if (wr_ins) begin
                instr_r <= pwdata[15:0];
                acks_r <= 4'h0;
            end else if (ack && acks_r != 4'hF) begin
                acks_r <= acks_r + 4'h1;
            end
            if (ack && acks_r == 4'h0) begin
                ptr_r <= mem_rdata;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pointer word read, then operand access at that pointer
    sequence s_ptr_read;
        ack && acks_r == 4'h0 && defer;
    endsequence
    sequence s_ptr_use;
        ##[0:3] (mem_req && mem_addr == ptr_r);
    endsequence
    reg_quiet_a: assert property (
        wr_ins && pwdata[15:12] == 4'h1 && pwdata[11:9] == 3'h0 && pwdata[5:3] == 3'h0
        |=> !mem_req [*6]) else $error("memory used in register mode");
    req_hold_a: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    defer_ptr_a: assert property (s_ptr_read |=> s_ptr_use)
        else $error("operand not fetched at pointer");
    word_write_a: assert property (mem_req && mem_we && is_w |-> !mem_byte)
        else $error("word move wrote a byte");
    byte_write_a: assert property (
        mem_req && mem_we && is_b |-> mem_byte && mem_wdata[15:8] == mem_wdata[7:0])
        else $error("byte move write malformed");
    group_dbl_a: assert property (
        rd_st && instr_r[14:12] >= 3'h1 && instr_r[14:12] <= 3'h6 |-> prdata[4:2] == 3'h0)
        else $error("double operand group wrong");
    group_fp_a: assert property (
        rd_st && instr_r[15:12] == 4'hF |-> prdata[4:2] == 3'h6)
        else $error("floating group wrong");
    fp_hand_a: assert property (
        wr_ins && pwdata[15:12] == 4'hF |=> ##[0:3] (fp_valid && fp_instr == instr_r))
        else $error("floating opcode not handed over");
    fp_hold_a: assert property (fp_valid && !fp_done |=> fp_valid)
        else $error("handover dropped early");
    fp_quiet_a: assert property (fp_valid |-> !mem_req)
        else $error("memory used for floating opcode");
endmodule // oamu_core_chk

bind oamu_core oamu_core_chk u_chk (.*);

// ==== verif/oamu_mem_model.sv ====
// Main memory and coprocessor responder model
`timescale 1ns/1ps
module oamu_mem_model (
    // Clock, reset and slow-response select
    input  logic        pclk,
    input  logic        presetn,
    input  logic        slow,
    // Memory
    input  logic        mem_req,
    input  logic        mem_we,
    input  logic        mem_byte,
    input  logic [15:0] mem_addr,
    input  logic [15:0] mem_wdata,
    output logic        mem_ack,
    output logic [15:0] mem_rdata,
    // Coprocessor
    input  logic        fp_valid,
    output logic        fp_done
);
    logic [15:0] mem [0:511];
    logic [1:0]  wait_r;
    logic [1:0]  fpc_r;
    wire  [8:0]  idx = mem_addr[9:1];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_r <= 2'h0;
        end else if (!mem_ack && mem_req && wait_r == (slow ? 2'h3 : 2'h0)) begin
            wait_r <= 2'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem[idx];
            if (mem_we && !mem_byte) mem[idx] <= mem_wdata;
            if (mem_we && mem_byte && mem_addr[0]) mem[idx][15:8] <= mem_wdata[7:0];
            if (mem_we && mem_byte && !mem_addr[0]) mem[idx][7:0] <= mem_wdata[7:0];
        end else begin
            if (!mem_ack && mem_req) wait_r <= wait_r + 2'h1;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp_done <= 1'b0;
            fpc_r <= 2'h0;
        end else if (fp_done) begin
            fp_done <= 1'b0;
        end else if (fp_valid && fpc_r == 2'h2) begin
            fp_done <= 1'b1;
            fpc_r <= 2'h0;
        end else if (fp_valid) begin
            fpc_r <= fpc_r + 2'h1;
        end
    end
endmodule // oamu_mem_model

// ==== verif/tb_operand_address_mode_unit.sv ====
// Self-checking bench for the operand address-mode unit
`timescale 1ns/1ps
`include "oamu_consts.vh"
module tb_operand_address_mode_unit;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rv;
    logic        er;
    wire  [31:0] prdata;
    wire         pready, pslverr, mem_req, mem_we, mem_byte, mem_ack, fp_valid, fp_done;
    wire  [15:0] mem_addr, mem_wdata, mem_rdata, fp_instr;
    int          bad_count = 0;
    int          comparisons = 0;
    int          i;
    logic [15:0] grp_ins [6] = '{16'h7000, 16'h0A00, 16'h0100, 16'h0000, 16'h00A1, 16'hF000};
    always #25 pclk = ~pclk;
    oamu_core dut (.*);
    oamu_mem_model mdl (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
        apb(1'b1, a, {16'h0000, d});
        check({31'h0, er}, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rv, {16'h0000, e});
    endtask
    task automatic setr(input logic [2:0] n, input logic [15:0] v);
        wr({3'h1, n, 2'h0}, v, 1'b0);
    endtask
    task automatic getr(input logic [2:0] n, input logic [15:0] e);
        rd({3'h1, n, 2'h0}, e);
    endtask
    task automatic mset(input logic [15:0] a, input logic [15:0] v);
        mdl.mem[a[9:1]] = v;
    endtask
    task automatic mchk(input logic [15:0] a, input logic [15:0] e);
        check({16'h0000, mdl.mem[a[9:1]]}, {16'h0000, e});
    endtask
    task automatic run(input logic [15:0] ins);
        wr(`OAMU_A_INSTR, ins, 1'b0);
        rv = 32'h0000_0000;
        while (rv[1] !== 1'b1) apb(1'b0, `OAMU_A_STAT, 32'h0000_0000);
    endtask
    task automatic final_report();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) getr(i[2:0], 16'h0000);
        rd(`OAMU_A_PSW, 16'h0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check({31'h0, er}, 32'h0000_0001);
        wr(`OAMU_A_STAT, 16'h0005, 1'b1);
        $display("test reset_map done");
        setr(1, 16'h8000);
        wr(`OAMU_A_PSW, 16'h0003, 1'b0);
        run(16'h1042);
        check({29'h0, rv[4:2]}, 32'h0000_0000);
        getr(2, 16'h8000);
        rd(`OAMU_A_PSW, 16'h0009);
        setr(1, 16'h0100);
        mset(16'h0100, 16'h0000);
        setr(2, 16'h0120);
        mset(16'h0120, 16'hFFFF);
        run(16'h1252);
        mchk(16'h0120, 16'h0000);
        getr(1, 16'h0100);
        getr(2, 16'h0122);
        rd(`OAMU_A_PSW, 16'h0005);
        slow <= 1'b1;
        setr(3, 16'h0140);
        mset(16'h0140, 16'h0150);
        mset(16'h0150, 16'h1234);
        setr(4, 16'h0170);
        run(16'h16E4);
        slow <= 1'b0;
        mchk(16'h016E, 16'h1234);
        getr(3, 16'h0142);
        getr(4, 16'h016E);
        rd(`OAMU_A_EA, 16'h016E);
        $display("test gpr_modes_a done");
        setr(7, 16'h0200);
        mset(16'h0200, 16'h0006);
        setr(5, 16'h0182);
        mset(16'h0180, 16'h0160);
        mset(16'h0160, 16'h7F00);
        setr(0, 16'h01A0);
        run(16'h1B70);
        mchk(16'h01A6, 16'h7F00);
        getr(5, 16'h0180);
        getr(7, 16'h0202);
        setr(7, 16'h0200);
        mset(16'h0200, 16'h0004);
        setr(1, 16'h0100);
        mset(16'h0104, 16'h01C0);
        mset(16'h01C0, 16'hABCD);
        run(16'h1E42);
        getr(2, 16'hABCD);
        getr(7, 16'h0202);
        $display("test gpr_modes_b done");
        setr(7, 16'h0200);
        mset(16'h0200, 16'h5555);
        mset(16'h0202, 16'h01E0);
        run(16'h15DF);
        mchk(16'h01E0, 16'h5555);
        getr(7, 16'h0204);
        setr(7, 16'h0200);
        mset(16'h0200, 16'h0010);
        mset(16'h0212, 16'h0F0F);
        mset(16'h0202, 16'h000C);
        mset(16'h0210, 16'h01F0);
        run(16'h1DFF);
        mchk(16'h01F0, 16'h0F0F);
        getr(7, 16'h0204);
        $display("test pc_modes done");
        setr(1, 16'h0101);
        mset(16'h0100, 16'h8011);
        run(16'h9442);
        getr(2, 16'hFF80);
        getr(1, 16'h0102);
        rd(`OAMU_A_RES, 16'hFF80);
        setr(3, 16'h1200);
        setr(4, 16'h0171);
        mset(16'h0170, 16'hAAAA);
        run(16'h90E4);
        mchk(16'h0170, 16'hAA00);
        getr(4, 16'h0170);
        rd(`OAMU_A_PSW, 16'h0005);
        rd(`OAMU_A_RES, 16'h0000);
        $display("test byte_move done");
        for (i = 0; i < 6; i++) begin
            run(grp_ins[i]);
            check({29'h0, rv[4:2]}, i + 1);
        end
        $display("test groups done");
        final_report();
    end
endmodule // tb_operand_address_mode_unit
